// >>> core/ild_pkg.sv
package ild_pkg;
  // ---------------------------------------------------------------
  // Register map (word offsets are byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ILD_CFG0_ADDR   = 8'h00;
  localparam logic [7:0] ILD_CFG1_ADDR   = 8'h04;
  localparam logic [7:0] ILD_START_ADDR  = 8'h08;
  localparam logic [7:0] ILD_THR_ADDR    = 8'h0c;
  localparam logic [7:0] ILD_RESET_ADDR  = 8'h10;
  localparam logic [7:0] ILD_CFG27_ADDR  = 8'h14;
  localparam logic [7:0] ILD_STATUS_ADDR = 8'h18;
  localparam logic [7:0] ILD_LVL0_ADDR   = 8'h1c;
  localparam logic [7:0] ILD_LVL1_ADDR   = 8'h20;
  localparam logic [7:0] ILD_LVL2_ADDR   = 8'h24;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ILD_CFG0_TWOS_BIT   = 0;
  localparam int ILD_CFG0_INTERP_BIT = 1;
  localparam int ILD_CFG0_SYNCSEL_BIT = 3;
  localparam int ILD_CFG0_ONESHOT_BIT = 4;
  localparam int ILD_CFG1_PRE_LSB    = 14;
  localparam int ILD_CFG1_PRE_MSB    = 29;
  localparam int ILD_CFG27_SYNCEN_BIT = 17;
  localparam int ILD_CFG27_LSBONE_BIT = 23;
  localparam int ILD_STAT_READY_BIT  = 0;
  localparam int ILD_STAT_RUN_BIT    = 1;
  // ---------------------------------------------------------------
  // Widths, reset values, timing
  // ---------------------------------------------------------------
  localparam int ILD_ACC_W   = 32;
  localparam int ILD_CNT_W   = 18;
  localparam int ILD_RES_W   = 23;
  localparam int ILD_SRST_CYCLES = 10;
  localparam logic [31:0] ILD_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ILD_BAD_ADDR_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    ILD_IDLE = 2'b00,
    ILD_RUN  = 2'b01,
    ILD_DONE = 2'b11
  } ild_state_t;
endpackage

// >>> core/ild_sync2.sv
`timescale 1ns/10ps
module ild_sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // ild_sync2

// >>> core/ild_srst_stretch.sv
`timescale 1ns/10ps
module ild_srst_stretch
  import ild_pkg::*;
#(
  parameter int CYCLES = ILD_SRST_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic trig,
  output logic      srst
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      srst  <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        cnt_q <= 5'(CYCLES - 1);
        srst  <= 1'b1;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end else begin
        srst  <= 1'b0;
      end
    end
  end
endmodule // ild_srst_stretch

// >>> core/ild_level_detector.sv
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
// Function
// - Offset binary or two's complement input selectable
// - Gated mode takes sample when enable high
// - Interpolated mode zero-stuffs to clock rate
// - Rectify sample, add signed programmed threshold
// - Sum in 32-bit accumulator
// - 18-bit down-counter counts integration samples
// - Only upper 16 preload bits writable
// - Continuous or count-once-and-stop counter modes
// - Continuous mode latches at zero, then reloads
// - Sync enable bit lets sync restart integration
// - Start register write starts counter anytime
// - At zero, copy upper 23 accumulator bits
// - Start write never latches the accumulator
// - Each latch sets result-ready status flag
// - Reading level MSB byte clears ready flag
// - Result shown as three byte registers
// - Bit selects ones or zeros preload LSBs
// - Software reset stretched to ten cycles
// - Config bit selects sync output clock
module ild_level_detector
  import ild_pkg::*;
#(
  parameter int IN_W = 14
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic [IN_W-1:0] sample_in,
  input  wire logic            input_sample_enable,
  input  wire logic            front_sync_input,
  input  wire logic            sync_req,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  output logic                 sync_output_pin,
  output logic                 sync_on_back_end,
  output logic                 front_reset,
  output logic                 result_ready
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic ena_s, fsync_s, fsync_d_q;
  logic [IN_W-1:0] smp_m_q, smp_q;
  ild_sync2 u_sync_ena (
    .clk (clk_sys),
    .rst (rst),
    .ce  (ce),
    .d   (input_sample_enable),
    .q   (ena_s)
  );
  ild_sync2 u_sync_fs (
    .clk (clk_sys),
    .rst (rst),
    .ce  (ce),
    .d   (front_sync_input),
    .q   (fsync_s)
  );
  // Data bus is sampled twice as well so it stays aligned with enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      smp_m_q   <= '0;
      smp_q     <= '0;
      fsync_d_q <= 1'b0;
    end else if (ce) begin
      smp_m_q   <= sample_in;
      smp_q     <= smp_m_q;
      fsync_d_q <= fsync_s;
    end
  end
  wire fsync_rise = fsync_s & ~fsync_d_q;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [31:0] cfg0_q, cfg1_q, thr_q, cfg27_q;
  logic        ready_q;
  logic [ILD_RES_W-1:0] hold_q;
  ild_state_t  st_q;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = bus_req & wb_we_i;
  wire rd = bus_req & ~wb_we_i;
  wire start_wr = wr & (wb_adr_i == ILD_START_ADDR);
  wire srst_wr  = wr & (wb_adr_i == ILD_RESET_ADDR);
  wire msb_rd   = rd & (wb_adr_i == ILD_LVL2_ADDR);
  logic srst;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg0_q  <= ILD_CFG_RST;
      cfg1_q  <= ILD_CFG_RST;
      thr_q   <= ILD_CFG_RST;
      cfg27_q <= ILD_CFG_RST;
    end else if (ce && wr) begin
      case (wb_adr_i)
        ILD_CFG0_ADDR:  cfg0_q  <= merge(cfg0_q, wb_dat_i, wb_sel_i);
        ILD_CFG1_ADDR:  cfg1_q  <= merge(cfg1_q, wb_dat_i, wb_sel_i);
        ILD_THR_ADDR:   thr_q   <= merge(thr_q, wb_dat_i, wb_sel_i);
        ILD_CFG27_ADDR: cfg27_q <= merge(cfg27_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (rd) begin
        case (wb_adr_i)
          ILD_CFG0_ADDR:   wb_dat_o <= cfg0_q;
          ILD_CFG1_ADDR:   wb_dat_o <= cfg1_q;
          ILD_THR_ADDR:    wb_dat_o <= thr_q;
          ILD_CFG27_ADDR:  wb_dat_o <= cfg27_q;
          ILD_STATUS_ADDR: wb_dat_o <= {30'h0, st_q == ILD_RUN, ready_q};
          ILD_LVL0_ADDR:   wb_dat_o <= {24'h0, hold_q[7:0]};
          ILD_LVL1_ADDR:   wb_dat_o <= {24'h0, hold_q[15:8]};
          ILD_LVL2_ADDR:   wb_dat_o <= {24'h0, hold_q[22:16], 1'b0};
          default:         wb_dat_o <= ILD_BAD_ADDR_DATA;
        endcase
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software reset and sync output
  // ---------------------------------------------------------------
  ild_srst_stretch #(.CYCLES(ILD_SRST_CYCLES)) u_srst (
    .clk  (clk_sys),
    .rst  (rst),
    .ce   (ce),
    .trig (srst_wr),
    .srst (srst)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      front_reset      <= 1'b0;
      sync_output_pin  <= 1'b0;
      sync_on_back_end <= 1'b0;
    end else if (ce) begin
      front_reset      <= srst;
      // Back-end domain is outside this block; flag tells it to take over
      sync_on_back_end <= cfg0_q[ILD_CFG0_SYNCSEL_BIT];
      sync_output_pin  <= sync_req & ~cfg0_q[ILD_CFG0_SYNCSEL_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Sample front end
  // ---------------------------------------------------------------
  logic signed [IN_W-1:0] smp_tc;
  logic                   smp_vld;
  logic signed [IN_W:0]   mag;
  logic signed [ILD_ACC_W-1:0] term;
  always_comb begin
    smp_tc = cfg0_q[ILD_CFG0_TWOS_BIT] ? smp_q
             : {~smp_q[IN_W-1], smp_q[IN_W-2:0]};
    // Interpolated: every clock counts, non-enabled clocks carry zero
    smp_vld = cfg0_q[ILD_CFG0_INTERP_BIT] ? 1'b1 : ena_s;
    if (cfg0_q[ILD_CFG0_INTERP_BIT] && !ena_s) begin
      smp_tc = '0;
    end
    mag  = smp_tc[IN_W-1] ? -{smp_tc[IN_W-1], smp_tc} : {smp_tc[IN_W-1], smp_tc};
    term = ILD_ACC_W'(mag) + $signed(thr_q);
  end

  // ---------------------------------------------------------------
  // Integration control
  // ---------------------------------------------------------------
  logic [ILD_CNT_W-1:0] cnt_q, preload;
  logic [ILD_ACC_W-1:0] acc_q;
  logic [ILD_ACC_W-1:0] acc_sum;
  // The sample that expires the count still belongs to the period
  assign acc_sum = acc_q + term;
  wire oneshot = cfg0_q[ILD_CFG0_ONESHOT_BIT];
  wire restart = start_wr | (fsync_rise & cfg27_q[ILD_CFG27_SYNCEN_BIT]);
  // relies on software; the low preload bits are fixed here
  assign preload = {cfg1_q[ILD_CFG1_PRE_MSB:ILD_CFG1_PRE_LSB],
                    {2{cfg27_q[ILD_CFG27_LSBONE_BIT]}}};
  wire expire = (st_q == ILD_RUN) && smp_vld && (cnt_q == 18'h00001);

  always_ff @(posedge clk_sys) begin
    if (rst || srst) begin
      st_q  <= ILD_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      case (st_q)
        ILD_IDLE, ILD_DONE: begin
          if (restart) begin
            st_q  <= ILD_RUN;
            cnt_q <= preload;
          end
        end
        ILD_RUN: begin
          if (restart) begin
            cnt_q <= preload;
          end else if (smp_vld) begin
            if (expire) begin
              cnt_q <= preload;
              st_q  <= oneshot ? ILD_DONE : ILD_RUN;
            end else begin
              cnt_q <= cnt_q - 18'h00001;
            end
          end
        end
        default: st_q <= ILD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || srst) begin
      acc_q <= '0;
    end else if (ce) begin
      if (restart || expire) begin
        acc_q <= '0;
      end else if (st_q == ILD_RUN && smp_vld) begin
        acc_q <= acc_sum;
      end
    end
  end

  // Restart wins over expiry so a start write never latches
  always_ff @(posedge clk_sys) begin
    if (rst || srst) begin
      hold_q  <= '0;
      ready_q <= 1'b0;
    end else if (ce) begin
      if (expire && !restart) begin
        hold_q  <= acc_sum[ILD_ACC_W-1 -: ILD_RES_W];
        ready_q <= 1'b1;
      end else if (msb_rd) begin
        ready_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_ready <= 1'b0;
    end else if (ce) begin
      result_ready <= ready_q;
    end
  end
endmodule // ild_level_detector

// >>> verif/ild_properties.sv
`timescale 1ns/10ps
module ild_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        sync_req,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sync_output_pin,
  input wire logic        sync_on_back_end,
  input wire logic        front_reset,
  input wire logic        result_ready
);
  logic       req;
  logic [3:0] rd2_q;
  logic [4:0] hi_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Ready may drop a few cycles after the clearing read
  always_ff @(posedge clk_sys) begin
    rd2_q <= {rd2_q[2:0], req && !wb_we_i && wb_adr_i == 8'h24};
  end
  always_ff @(posedge clk_sys) begin
    hi_q <= front_reset ? hi_q + 5'h01 : 5'h00;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  bad_adr_zero_a: assert property (req && !wb_we_i
    && (wb_adr_i > 8'h24 || wb_adr_i[1:0] != 2'h0) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  level_msb_a: assert property (req && !wb_we_i && wb_adr_i == 8'h24
    |=> wb_dat_o[0] == 1'b0 && wb_dat_o[31:8] == 24'h0)
    else $error("level msb byte badly formed");
  ready_clear_a: assert property ($fell(result_ready)
    |-> (|rd2_q) || front_reset) else $error("ready fell without read");
  srst_width_a: assert property ($fell(front_reset) |-> hi_q == 5'h0a)
    else $error("soft reset width wrong");
  srst_start_a: assert property (req && wb_we_i && wb_adr_i == 8'h10
    |-> ##[1:4] front_reset) else $error("soft reset not started");
  sync_out_a: assert property (sync_req && !sync_on_back_end && !front_reset
    ##1 !sync_on_back_end && !front_reset |-> sync_output_pin)
    else $error("sync output missed");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst |=> !wb_ack_o && !front_reset && !result_ready)
    else $error("output active after reset");
endmodule // ild_chk

bind ild_level_detector ild_chk u_chk (.*);

// >>> verif/ild_adc_model.sv
`timescale 1ns/10ps
module ild_adc_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        fast,
  input  wire logic [13:0] code,
  output logic [13:0]      sample,
  output logic             valid
);
  // Off-strobe the bus is not held: show the inverse to expose stray takes
  always_ff @(posedge clk_sys) begin
    valid  <= !rst && (fast || !valid);
    sample <= (!rst && (fast || !valid)) ? code : ~code;
  end
endmodule // ild_adc_model

// >>> verif/ild_level_detector_tb.sv
`timescale 1ns/10ps
module ild_level_detector_tb;
  import ild_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        fast = 1'b0;
  logic        fsync = 1'b0;
  logic        sreq = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [13:0] code = 14'h0;
  logic [13:0] smp;
  logic        ack, vld, sob, frst, ready;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) sreq <= ~sreq;
  ild_level_detector #(.IN_W(14)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .sample_in(smp),
    .input_sample_enable(vld), .front_sync_input(fsync), .sync_req(sreq),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sync_output_pin(), .sync_on_back_end(sob), .front_reset(frst),
    .result_ready(ready));
  ild_adc_model adc (.clk_sys(clk_sys), .rst(rst), .fast(fast), .code(code),
    .sample(smp), .valid(vld));
  // ----
  // Tasks
  // ----
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dat_o;
    if (ack !== 1'b1) begin
      $display("MISMATCH wb_ack_o exp 1 got %b", ack);
      n_mismatch++;
      close_out();
    end
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitr(input int n);
    for (int i = 0; i < n && ready !== 1'b1; i++) @(posedge clk_sys);
  endtask
  task automatic pulse;
    fsync <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fsync <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic level(input logic [31:0] acc);
    logic [7:0] l0;
    logic [7:0] l1;
    bus(0, ILD_LVL0_ADDR, 0);
    l0 = rdat[7:0];
    bus(0, ILD_LVL1_ADDR, 0);
    l1 = rdat[7:0];
    bus(0, ILD_LVL2_ADDR, 0);
    chk("level", {9'h0, acc[31:9]}, {9'h0, rdat[7:1], l1, l0});
  endtask
  // Low preload bits are garbage on purpose: only the field may count
  task automatic run(input logic [31:0] c0, input logic [31:0] c27,
                     input logic [31:0] thr, input logic [13:0] x, input logic f,
                     input logic [31:0] acc);
    code <= x;
    fast <= f;
    bus(1, ILD_CFG0_ADDR, c0);
    bus(1, ILD_CFG27_ADDR, c27);
    bus(1, ILD_THR_ADDR, thr);
    bus(1, ILD_CFG1_ADDR, 32'hc000_bfff);
    bus(1, ILD_START_ADDR, 0);
    repeat (2) begin
      bus(1, ILD_START_ADDR, 0);
      if (c0[4]) chk("ready_restart", 0, ready);
      waitr(300);
      chk("ready", 1, ready);
      level(acc);
      if (c0[4]) begin
        bus(0, ILD_STATUS_ADDR, 0);
        chk("ready_clear", 0, rdat[ILD_STAT_READY_BIT]);
      end
    end
    $display("case cfg0 %h done", c0);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(0, ILD_CFG0_ADDR, 0);
    chk("cfg0", ILD_CFG_RST, rdat);
    bus(1, 8'h3c, 32'hffff_ffff);
    bus(0, 8'h3c, 0);
    chk("unmapped", ILD_BAD_ADDR_DATA, rdat);
    bus(1, ILD_RESET_ADDR, 0);
    for (int i = 0; i < 8 && frst !== 1'b1; i++) @(posedge clk_sys);
    chk("front_reset", 1, frst);
    repeat (20) @(posedge clk_sys);
    bus(1, ILD_CFG0_ADDR, 32'h8);
    repeat (2) @(posedge clk_sys);
    chk("sync_sel", 1, sob);
    $display("setup done");
    run(32'h11, 0, -32'sd1000, 14'h20c0, 0, 8 * 7000);
    run(32'h10, 32'h0080_0000, 0, 14'h0000, 1, 11 * 8192);
    run(32'h03, 0, 0, 14'h1f40, 0, 4 * 8000);
    bus(1, ILD_CFG0_ADDR, 32'h11);
    waitr(100);
    // Let a period begun before the mode change run out and stop
    repeat (40) @(posedge clk_sys);
    bus(0, ILD_LVL2_ADDR, 0);
    pulse();
    repeat (60) @(posedge clk_sys);
    chk("sync_off", 0, ready);
    bus(1, ILD_CFG27_ADDR, 32'h0002_0000);
    pulse();
    waitr(300);
    chk("sync_on", 1, ready);
    level(8 * 8000);
    $display("sync done");
    close_out();
  end
endmodule // ild_level_detector_tb
